//--- ptpfts_cfg.svh
// register offsets, field positions and reset values of the ptp filter/trigger status bank
// assumes a 12-bit byte address on the register bus
`ifndef PTPFTS_CFG_SVH
`define PTPFTS_CFG_SVH
`define PTPFTS_OFF_FILTER 12'h518
`define PTPFTS_OFF_INDEX 12'h520
`define PTPFTS_OFF_TRGSTAT 12'h524
`define PTPFTS_OFF_WIN_LO 12'h52c
`define PTPFTS_OFF_WIN_HI 12'h5b3
`define PTPFTS_OFF_IRQ_STAT 12'h600
`define PTPFTS_OFF_IRQ_CLR 12'h604
`define PTPFTS_OFF_IRQ_EN 12'h608
`define PTPFTS_VER_MSB 11
`define PTPFTS_VER_LSB 8
`define PTPFTS_DOM_MSB 7
`define PTPFTS_DOM_LSB 0
`define PTPFTS_VER_RST 4'h2
`define PTPFTS_DOM_RST 8'h00
`define PTPFTS_TS_SEL_BIT 8
`define PTPFTS_TRIG_SEL_MSB 1
`define PTPFTS_TRIG_SEL_LSB 0
`define PTPFTS_TS_SEL_RST 1'b0
`define PTPFTS_TRIG_SEL_RST 2'h0
`define PTPFTS_TRIG_SEL_RSVD 2'h3
`define PTPFTS_ERR_MSB 18
`define PTPFTS_ERR_LSB 16
`define PTPFTS_DONE_MSB 2
`define PTPFTS_DONE_LSB 0
`define PTPFTS_RESP_OKAY 2'h0
`define PTPFTS_RESP_SLVERR 2'h2
`define PTPFTS_MEM_AW 9
`endif

//--- ptpfts_pkg.sv
// types shared by the ptp filter/trigger status bank
// assumes ptpfts_cfg.svh is on the include path
package ptpfts_pkg;
  // one received timing message header, valid for one cycle
  typedef struct packed {
    logic valid;
    logic [3:0] version;
    logic [7:0] domain;
    logic domain_check_en;
  } ptpfts_rx_msg_t;
  // filter verdict, one-cycle pulses
  typedef struct packed {
    logic capture;
    logic drop;
  } ptpfts_rx_res_t;
  // per trigger unit events and levels, bit n = unit n
  typedef struct packed {
    logic [2:0] done;
    logic [2:0] late;
    logic [2:0] event_notify_enable;
    logic [2:0] enable_wr_zero;
  } ptpfts_unit_evt_t;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_DATA, RD_RESP} ptpfts_rd_state_t;
endpackage

//--- ptpfts_mem.sv
// window storage for the per-unit registers, one word per address
// assumes one write and one read port on sys_clk; contents are not reset
`timescale 1ns/1ps
module ptpfts_mem (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [8:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic re,
  input wire logic [8:0] raddr,
  output logic [31:0] rdata_q
);
  logic [31:0] mem [0:511];
  logic [31:0] rdata_d;

  // read data registered, held when no read
  always_comb
  begin
    rdata_d = rdata_q;
    if (re)
    begin
      rdata_d = mem[raddr];
    end
  end

  // array has no reset to stay a plain ram
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (rst)
    begin
      rdata_q <= 32'h0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end
endmodule

//--- ptpfts_top.sv
// ptp version/domain filter, unit index, trigger status flags and interrupt block on an axi4-lite slave
// assumes same-clock event inputs from the trigger units and the receive parser
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ptpfts_cfg.svh"
module ptpfts_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire ptpfts_pkg::ptpfts_rx_msg_t rx_msg,
  output ptpfts_pkg::ptpfts_rx_res_t rx_res,
  input wire ptpfts_pkg::ptpfts_unit_evt_t unit_evt,
  output logic irq
);
  import ptpfts_pkg::*;

  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d, arready_q, arready_d;
  logic rvalid_q, rvalid_d, aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [11:0] awaddr_q, awaddr_d, araddr_q, araddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  ptpfts_rd_state_t rd_q, rd_d;
  logic [3:0] ver_q, ver_d;
  logic [7:0] dom_q, dom_d;
  logic ts_sel_q, ts_sel_d;
  logic [1:0] trig_sel_q, trig_sel_d;
  logic [2:0] err_q, err_d, done_q, done_d;
  logic [31:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic irq_q, irq_d;
  ptpfts_rx_res_t rx_res_q, rx_res_d;
  logic wr_do, mem_we, mem_re;
  logic [8:0] mem_waddr, mem_raddr;
  logic [31:0] mem_rdata, reg_mask, w1c, evt_word;
  logic [2:0] err_set, done_set, err_wclr;
  logic [11:0] wa;

  // byte lanes of a write strobe as a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic in_window(input logic [11:0] a);
    return (a >= `PTPFTS_OFF_WIN_LO) && (a <= `PTPFTS_OFF_WIN_HI);
  endfunction

  // unit index bits on top so each unit pair gets its own copy of the window
  function automatic logic [8:0] win_index(input logic [11:0] a, input logic ts, input logic [1:0] trig);
    logic [11:0] off;
    off = a - `PTPFTS_OFF_WIN_LO;
    return {ts, trig, off[7:2]};
  endfunction

  ptpfts_mem u_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(wdata_q),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

  // event terms shared by flags and interrupt status
  always_comb
  begin
    err_set = unit_evt.late & unit_evt.event_notify_enable;
    done_set = unit_evt.done & unit_evt.event_notify_enable;
    err_wclr = unit_evt.enable_wr_zero;
    evt_word = 32'h0;
    evt_word[`PTPFTS_ERR_MSB:`PTPFTS_ERR_LSB] = err_set;
    evt_word[`PTPFTS_DONE_MSB:`PTPFTS_DONE_LSB] = done_set;
  end

  // bus channels, register writes, read mux and flags
  always_comb
  begin
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    rd_d = rd_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    araddr_d = araddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    ver_d = ver_q;
    dom_d = dom_q;
    ts_sel_d = ts_sel_q;
    trig_sel_d = trig_sel_q;
    irq_en_d = irq_en_q;
    mem_we = 1'b0;
    mem_re = 1'b0;
    w1c = 32'h0;
    wa = {awaddr_q[11:2], 2'h0};
    reg_mask = lane_mask(wstrb_q);
    mem_waddr = win_index(wa, ts_sel_q, trig_sel_q);
    mem_raddr = win_index({araddr_q[11:2], 2'h0}, ts_sel_q, trig_sel_q);
    if (awvalid && awready_q)
    begin
      aw_full_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_full_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    wr_do = aw_full_q && w_full_q && !bvalid_q;
    if (bvalid_q && bready)
    begin
      bvalid_d = 1'b0;
    end
    // write decode; only the documented field bits take data, except window writes, which store the whole wdata_q word whatever wstrb says
    if (wr_do)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `PTPFTS_RESP_OKAY;
      if (wa == `PTPFTS_OFF_FILTER)
      begin
        if (wstrb_q[1])
        begin
          ver_d = wdata_q[`PTPFTS_VER_MSB:`PTPFTS_VER_LSB];
        end
        if (wstrb_q[0])
        begin
          dom_d = wdata_q[`PTPFTS_DOM_MSB:`PTPFTS_DOM_LSB];
        end
      end
      else if (wa == `PTPFTS_OFF_INDEX)
      begin
        if (wstrb_q[1])
        begin
          ts_sel_d = wdata_q[`PTPFTS_TS_SEL_BIT];
        end
        if (wstrb_q[0])
        begin
          trig_sel_d = wdata_q[`PTPFTS_TRIG_SEL_MSB:`PTPFTS_TRIG_SEL_LSB];
        end
      end
      else if (wa == `PTPFTS_OFF_TRGSTAT || wa == `PTPFTS_OFF_IRQ_CLR)
      begin
        w1c = wdata_q & reg_mask;
      end
      else if (wa == `PTPFTS_OFF_IRQ_EN)
      begin
        irq_en_d = (irq_en_q & ~reg_mask) | (wdata_q & reg_mask);
      end
      else if (in_window(wa))
      begin
        // reserved trigger index reaches no unit, write is dropped
        mem_we = (trig_sel_q != `PTPFTS_TRIG_SEL_RSVD);
      end
      else if (wa != `PTPFTS_OFF_IRQ_STAT)
      begin
        bresp_d = `PTPFTS_RESP_SLVERR;
      end
    end
    irq_en_d[31:19] = 13'h0;
    irq_en_d[15:3] = 13'h0;
    // flags: a set in the same cycle as a clear wins
    err_d = (err_q & ~err_wclr) | err_set;
    done_d = done_q | done_set;
    if (wa == `PTPFTS_OFF_TRGSTAT)
    begin
      err_d = (err_q & ~err_wclr & ~w1c[`PTPFTS_ERR_MSB:`PTPFTS_ERR_LSB]) | err_set;
      done_d = (done_q & ~w1c[`PTPFTS_DONE_MSB:`PTPFTS_DONE_LSB]) | done_set;
      irq_stat_d = irq_stat_q | evt_word;
    end
    else
    begin
      irq_stat_d = (irq_stat_q & ~w1c) | evt_word;
    end
    irq_d = |(irq_stat_d & irq_en_d);
    // read side: fetch one cycle, answer the next
    case (rd_q)
      RD_IDLE:
      begin
        if (arvalid && arready_q)
        begin
          araddr_d = araddr;
          rd_d = RD_FETCH;
        end
      end
      RD_FETCH:
      begin
        mem_re = 1'b1;
        rd_d = RD_DATA;
      end
      RD_DATA:
      begin
        rdata_d = 32'h0;
        rresp_d = `PTPFTS_RESP_OKAY;
        if ({araddr_q[11:2], 2'h0} == `PTPFTS_OFF_FILTER)
        begin
          rdata_d[`PTPFTS_VER_MSB:`PTPFTS_VER_LSB] = ver_q;
          rdata_d[`PTPFTS_DOM_MSB:`PTPFTS_DOM_LSB] = dom_q;
        end
        else if ({araddr_q[11:2], 2'h0} == `PTPFTS_OFF_INDEX)
        begin
          rdata_d[`PTPFTS_TS_SEL_BIT] = ts_sel_q;
          rdata_d[`PTPFTS_TRIG_SEL_MSB:`PTPFTS_TRIG_SEL_LSB] = trig_sel_q;
        end
        else if ({araddr_q[11:2], 2'h0} == `PTPFTS_OFF_TRGSTAT)
        begin
          rdata_d[`PTPFTS_ERR_MSB:`PTPFTS_ERR_LSB] = err_q;
          rdata_d[`PTPFTS_DONE_MSB:`PTPFTS_DONE_LSB] = done_q;
        end
        else if ({araddr_q[11:2], 2'h0} == `PTPFTS_OFF_IRQ_STAT)
        begin
          rdata_d = irq_stat_q;
        end
        else if ({araddr_q[11:2], 2'h0} == `PTPFTS_OFF_IRQ_EN)
        begin
          rdata_d = irq_en_q;
        end
        else if (in_window({araddr_q[11:2], 2'h0}))
        begin
          if (trig_sel_q != `PTPFTS_TRIG_SEL_RSVD)
          begin
            rdata_d = mem_rdata;
          end
        end
        else if ({araddr_q[11:2], 2'h0} != `PTPFTS_OFF_IRQ_CLR)
        begin
          rresp_d = `PTPFTS_RESP_SLVERR;
        end
        rvalid_d = 1'b1;
        rd_d = RD_RESP;
      end
      default:
      begin
        if (rready)
        begin
          rvalid_d = 1'b0;
          rd_d = RD_IDLE;
        end
      end
    endcase
    // readies registered from next state so every output is a flop
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
    arready_d = (rd_d == RD_IDLE);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
      rd_q <= RD_IDLE;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 12'h0;
      araddr_q <= 12'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      ver_q <= `PTPFTS_VER_RST;
      dom_q <= `PTPFTS_DOM_RST;
      ts_sel_q <= `PTPFTS_TS_SEL_RST;
      trig_sel_q <= `PTPFTS_TRIG_SEL_RST;
      err_q <= 3'h0;
      done_q <= 3'h0;
      irq_stat_q <= 32'h0;
      irq_en_q <= 32'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      rd_q <= rd_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      araddr_q <= araddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      ver_q <= ver_d;
      dom_q <= dom_d;
      ts_sel_q <= ts_sel_d;
      trig_sel_q <= trig_sel_d;
      err_q <= err_d;
      done_q <= done_d;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  // receive filter verdict, one cycle after the header
  always_comb
  begin
    rx_res_d.capture = 1'b0;
    rx_res_d.drop = 1'b0;
    if (rx_msg.valid)
    begin
      if (rx_msg.version != ver_q)
      begin
        rx_res_d.drop = 1'b1;
      end
      else if (rx_msg.domain_check_en && rx_msg.domain != dom_q)
      begin
        rx_res_d.drop = 1'b1;
      end
      else
      begin
        rx_res_d.capture = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_res_q <= '0;
    end
    else
    begin
      rx_res_q <= rx_res_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign rx_res = rx_res_q;
  assign irq = irq_q;

  // checks next to the logic they guard
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ver_ok;
    rx_msg.valid && rx_msg.version == ver_q;
  endsequence
  sequence s_win_read;
    arvalid && arready_q && in_window({araddr[11:2], 2'h0});
  endsequence

  property p_ver_capture;
    s_ver_ok and (rx_msg.domain_check_en && rx_msg.domain == dom_q) |=> rx_res_q.capture && !rx_res_q.drop;
  endproperty
  a_ver_capture: assert property (p_ver_capture) else $error("matching message not captured");
  property p_ver_drop;
    rx_msg.valid && rx_msg.version != ver_q |=> rx_res_q.drop && !rx_res_q.capture;
  endproperty
  a_ver_drop: assert property (p_ver_drop) else $error("version mismatch not dropped");
  property p_dom_gate;
    s_ver_ok and (rx_msg.domain_check_en && rx_msg.domain != dom_q) |=> !rx_res_q.capture;
  endproperty
  a_dom_gate: assert property (p_dom_gate) else $error("domain mismatch captured");
  property p_dom_ignore;
    s_ver_ok and !rx_msg.domain_check_en |=> rx_res_q.capture;
  endproperty
  a_dom_ignore: assert property (p_dom_ignore) else $error("domain not ignored");
  property p_win_route;
    s_win_read ##1 (trig_sel_q != `PTPFTS_TRIG_SEL_RSVD) ##2 1'b1 |-> rvalid_q && rdata_q == mem_rdata;
  endproperty
  a_win_route: assert property (p_win_route) else $error("window read not from memory");
  property p_ts_sel;
    s_win_read |=> mem_raddr[8] == ts_sel_q && mem_raddr[7:6] == trig_sel_q;
  endproperty
  a_ts_sel: assert property (p_ts_sel) else $error("window not indexed by unit select");
  property p_rsvd_sel;
    mem_we |-> trig_sel_q != `PTPFTS_TRIG_SEL_RSVD;
  endproperty
  a_rsvd_sel: assert property (p_rsvd_sel) else $error("reserved trigger index written");
  property p_err_set;
    err_set != 3'h0 |=> (err_q & $past(err_set)) == $past(err_set) ##[1:2] irq_q || irq_en_q[18:16] == 3'h0;
  endproperty
  a_err_set: assert property (p_err_set) else $error("late trigger not flagged");
  property p_err_clr;
    (err_wclr & ~err_set) != 3'h0 |=> (err_q & $past(err_wclr) & ~$past(err_set)) == 3'h0;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error flag not cleared");
  property p_done_set;
    done_set != 3'h0 |=> (done_q & $past(done_set)) == $past(done_set);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");
  property p_rsvd_zero;
    rvalid_q && {araddr_q[11:2], 2'h0} == `PTPFTS_OFF_INDEX |-> rdata_q[31:9] == 23'h0 && rdata_q[7:2] == 6'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved index bits nonzero");
endmodule

//--- test_ptpfts_top.sv
// self-checking bench for the ptp filter/trigger status bank
// assumes ptpfts_pkg is compiled first and ptpfts_cfg.svh is on the include path
`timescale 1ns/1ps
`include "ptpfts_cfg.svh"
module test_ptpfts_top;
  import ptpfts_pkg::*;
  localparam logic [11:0] a_flt = `PTPFTS_OFF_FILTER;
  localparam logic [11:0] a_idx = `PTPFTS_OFF_INDEX;
  localparam logic [11:0] a_trg = `PTPFTS_OFF_TRGSTAT;
  localparam logic [11:0] a_wlo = `PTPFTS_OFF_WIN_LO;
  localparam logic [11:0] a_ist = `PTPFTS_OFF_IRQ_STAT;
  localparam logic [11:0] a_icl = `PTPFTS_OFF_IRQ_CLR;
  localparam logic [11:0] a_ien = `PTPFTS_OFF_IRQ_EN;
  localparam logic [1:0] ok = `PTPFTS_RESP_OKAY;
  localparam logic [1:0] slverr = `PTPFTS_RESP_SLVERR;
  logic sys_clk, rst;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  ptpfts_rx_msg_t rx_msg;
  ptpfts_rx_res_t rx_res;
  ptpfts_unit_evt_t unit_evt;
  int num_errors, comparisons;
  logic [3:0] cur_ver;
  logic [7:0] cur_dom;
  logic [31:0] win_exp [8];
  logic [11:0] win_adr [8];

  ptpfts_top u_ptpfts_top (.sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx_msg(rx_msg), .rx_res(rx_res), .unit_evt(unit_evt), .irq(irq));

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bus write; each channel released at its own handshake, bounded wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 0;
    for (int i = 0; i < 64 && !done; i++)
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      num_errors++;
      final_report();
    end
  endtask

  // bus read with compare of data and response
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er, input string name);
    bit done;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 0;
    for (int i = 0; i < 64 && !done; i++)
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        check(name, rdata, ed);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      num_errors++;
      final_report();
    end
  endtask

  // one-cycle message; returns at the edge where the verdict is visible
  task automatic send_msg(input logic [3:0] v, input logic [7:0] dm, input logic chk);
    @(posedge sys_clk);
    rx_msg <= '{1'b1, v, dm, chk};
    @(posedge sys_clk);
    rx_msg.valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one-cycle unit event pulses with a notify level held afterwards
  task automatic evt(input logic [2:0] late, input logic [2:0] dn, input logic [2:0] wz, input logic [2:0] nt);
    @(posedge sys_clk);
    unit_evt <= '{dn, late, nt, wz};
    @(posedge sys_clk);
    unit_evt <= '{3'h0, 3'h0, nt, 3'h0};
    repeat (2) @(posedge sys_clk);
  endtask

  // expected {capture, drop} from the programmed version and domain
  function automatic logic [1:0] filt_exp(input logic [3:0] v, input logic [7:0] dm, input logic chk);
    logic hit;
    hit = (v == cur_ver) && (!chk || dm == cur_dom);
    return {hit, !hit};
  endfunction

  initial
  begin
    logic [31:0] d;
    logic [3:0] v;
    logic [7:0] dm;
    logic chk;
    logic [2:0] m;
    logic [31:0] sel;
    rst = 1'b1;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = '0;
    wstrb = 4'hf;
    rx_msg = '0;
    unit_evt = '0;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(35));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // reset values
    rd_chk(a_flt, 32'h0000_0200, ok, "filter_rst");
    rd_chk(a_idx, 32'h0, ok, "index_rst");
    rd_chk(a_trg, 32'h0, ok, "flags_rst");
    cur_ver = 4'h2;
    cur_dom = 8'h00;
    // receive filter with random headers, matches and misses mixed
    for (int i = 0; i < 36; i++)
    begin
      if (i % 6 == 5)
      begin
        d = $urandom;
        wr(a_flt, d, ok);
        cur_ver = d[11:8];
        cur_dom = d[7:0];
        rd_chk(a_flt, {20'h0, d[11:0]}, ok, "filter");
      end
      v = ($urandom % 2) ? cur_ver : 4'($urandom);
      dm = ($urandom % 2) ? cur_dom : 8'($urandom);
      chk = 1'($urandom);
      send_msg(v, dm, chk);
      check("rx_res", {30'h0, rx_res}, {30'h0, filt_exp(v, dm, chk)});
    end
    // window routing: one word per unit pair, reserved trigger select included
    for (int k = 0; k < 8; k++)
    begin
      d = $urandom;
      sel = {23'h0, k[2], 6'h0, k[1:0]};
      win_adr[k] = a_wlo + 12'(4 * ($urandom % 34));
      win_exp[k] = (k % 4 == 3) ? 32'h0 : d;
      wr(a_idx, ($urandom & 32'hffff_fefc) | sel, ok);
      rd_chk(a_idx, sel, ok, "index");
      wr(win_adr[k], d, ok);
    end
    // read back in reverse, each right after its index write
    for (int k = 7; k >= 0; k--)
    begin
      wr(a_idx, {23'h0, k[2], 6'h0, k[1:0]}, ok);
      rd_chk(win_adr[k], win_exp[k], ok, "window");
    end
    // per-unit error and done flags and interrupt
    wr(a_ien, 32'hffff_ffff, ok);
    rd_chk(a_ien, 32'h0007_0007, ok, "irq_en");
    for (int n = 0; n < 3; n++)
    begin
      m = 3'b1 << n;
      evt(m, 3'h0, 3'h0, 3'h7);
      rd_chk(a_trg, {13'h0, m, 16'h0}, ok, "err_set");
      check("irq_err", {31'h0, irq}, 32'h1);
      evt(3'h0, 3'h0, m, 3'h7);
      rd_chk(a_trg, 32'h0, ok, "err_clr");
      evt(3'h0, m, 3'h0, 3'h7);
      rd_chk(a_trg, {29'h0, m}, ok, "done_set");
      rd_chk(a_ist, {13'h0, m, 13'h0, m}, ok, "irq_stat");
      wr(a_trg, {13'h0, m, 13'h0, m}, ok);
      rd_chk(a_trg, 32'h0, ok, "done_clr");
      wr(a_icl, 32'hffff_ffff, ok);
      rd_chk(a_ist, 32'h0, ok, "irq_clr");
      check("irq_idle", {31'h0, irq}, 32'h0);
      evt(m, m, 3'h0, ~m);
      rd_chk(a_trg, 32'h0, ok, "no_notify");
    end
    // masked source keeps the output low until enabled
    wr(a_ien, 32'h0, ok);
    evt(3'h0, 3'h4, 3'h0, 3'h7);
    rd_chk(a_ist, 32'h4, ok, "masked_stat");
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(a_ien, 32'h4, ok);
    rd_chk(a_ien, 32'h4, ok, "irq_en_one");
    check("irq_unmasked", {31'h0, irq}, 32'h1);
    wr(a_icl, 32'h4, ok);
    wr(a_trg, 32'h4, ok);
    rd_chk(a_ist, 32'h0, ok, "irq_stat_clr");
    // read-only, write-only and unmapped places
    wr(a_ist, 32'hffff_ffff, ok);
    rd_chk(a_ist, 32'h0, ok, "stat_ro");
    rd_chk(a_icl, 32'h0, ok, "clr_wo");
    wr(12'h700, $urandom, slverr);
    rd_chk(12'h700, 32'h0, slverr, "unmapped");
    rd_chk(a_trg, 32'h0, ok, "flags_end");
    final_report();
  end
endmodule
